// ==== cit_core.sv ====
/*
 * instruction timing core: classifies each instruction word by format,
 * works out its clk cycle count and code length from the addressing
 * modes, and sequences reset, interrupt entry and execution slots.
 * assumes instruction words, watchdog reset and interrupt request come
 * from logic on clk; the reset/nmi pin is asynchronous and synchronised.
 */
module cit_core
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    input  wire logic [15:0]   instr_word,
    input  wire logic          instr_valid,
    input  wire logic          irq_req,
    input  wire logic          watchdog_timer_rst,
    input  wire logic          rst_nmi_pin,
    output logic               instr_ready,
    output cit_pkg::cit_fmt_e  fmt_q,
    output logic [3:0]         op_q,
    output logic               byte_q,
    output cit_pkg::cit_mode_e mode_q,
    output cit_pkg::cit_dst_e  dst_q,
    output logic [2:0]         cycles_q,
    output logic [1:0]         words_q,
    output logic               illegal_q,
    output logic               unpredictable_q,
    output logic               done_q,
    output logic               irq_ack_q,
    output logic               reset_done_q,
    output cit_pkg::cit_state_e state_q
);

    logic                pin_sync;
    logic                reset_hold;
    logic                idle;
    logic                irq_take;
    logic                accept;
    logic                is_single;
    logic                is_jump;
    logic                is_double;
    logic                shift_grp;
    logic                single_bad;
    logic                illegal;
    logic [2:0]          dec_sub;
    logic [1:0]          src_as;
    logic [3:0]          src_reg;
    logic [3:0]          dst_reg;
    cit_pkg::cit_mode_e  src_mode;
    cit_pkg::cit_dst_e   dst_cls;
    cit_pkg::cit_fmt_e   dec_fmt;
    logic [3:0]          dec_op;
    logic [2:0]          sgl_cycles;
    logic [2:0]          dec_cycles;
    logic [1:0]          dec_words;
    cit_pkg::cit_state_e state_d;
    logic [2:0]          cnt_q;
    logic [2:0]          cnt_d;
    logic                done_d;
    logic                irq_ack_d;
    logic                reset_done_d;

    // reset/nmi pin crosses into clk before anything looks at it
    cit_sync u_pin_sync
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in (rst_nmi_pin),
        .sync_out (pin_sync)
    );

    // either reset source holds the sequencer at its start
    assign reset_hold = pin_sync | watchdog_timer_rst; // RL3

    // slot arbitration: reset over interrupt over instruction
    assign idle        = (state_q == cit_pkg::ST_IDLE);
    assign irq_take    = idle & irq_req & ~reset_hold;
    assign instr_ready = idle & ~irq_req & ~reset_hold;
    assign accept      = instr_ready & instr_valid;

    // format classification by opcode range
    assign is_single = (instr_word[cit_pkg::PFX1_HI:cit_pkg::PFX1_LO]
                        == cit_pkg::SINGLE_PFX); // RL14
    assign is_jump   = (instr_word[cit_pkg::PFX1_HI:cit_pkg::PFXJ_LO]
                        == cit_pkg::JUMP_PFX); // RL15
    assign is_double = (instr_word[cit_pkg::PFX1_HI:cit_pkg::TOP_LO]
                        >= cit_pkg::DOUBLE_MIN); // RL16

    // single operand sub-range and unused columns of the 1xxx row
    assign dec_sub    = instr_word[cit_pkg::SUB_HI:cit_pkg::SUB_LO]; // RL14
    assign shift_grp  = (dec_sub < cit_pkg::SUB_PUSH);
    assign single_bad = (dec_sub == cit_pkg::SUB_NONE)
                      | (instr_word[cit_pkg::BW_BIT]
                         & ((dec_sub == cit_pkg::SUB_SWAP)
                          | (dec_sub == cit_pkg::SUB_SEXT)
                          | (dec_sub == cit_pkg::SUB_CALL)
                          | (dec_sub == cit_pkg::SUB_RETURN_FROM_INTERRUPT)));
    assign illegal    = ~(is_single | is_jump | is_double)
                      | (is_single & single_bad);

    // source mode; single operand carries its operand in the low fields
    assign src_as   = instr_word[cit_pkg::AS_HI:cit_pkg::AS_LO];
    assign dst_reg  = instr_word[cit_pkg::DREG_HI:cit_pkg::DREG_LO];
    assign src_reg  = is_double ? instr_word[cit_pkg::SREG_HI:cit_pkg::SREG_LO]
                                : dst_reg;
    assign src_mode = (src_as == cit_pkg::AS_REG) ? cit_pkg::MODE_REG
                    : (src_as == cit_pkg::AS_IDX) ? cit_pkg::MODE_IDX
                    : (src_as == cit_pkg::AS_IND) ? cit_pkg::MODE_IND
                    : (src_reg == cit_pkg::REG_PC) ? cit_pkg::MODE_IMM
                    : cit_pkg::MODE_AINC;

    // destination class of a double operand instruction
    assign dst_cls = instr_word[cit_pkg::AD_BIT] ? cit_pkg::DST_MEM
                   : (dst_reg == cit_pkg::REG_PC) ? cit_pkg::DST_PC
                   : cit_pkg::DST_REG;

    // reported format and operation index
    assign dec_fmt = illegal   ? cit_pkg::FMT_ILLEGAL
                   : is_jump   ? cit_pkg::FMT_JUMP
                   : is_double ? cit_pkg::FMT_DOUBLE
                   : cit_pkg::FMT_SINGLE;
    assign dec_op  = is_double ? instr_word[cit_pkg::PFX1_HI:cit_pkg::TOP_LO] // RL16
                   : is_jump   ? {cit_pkg::OP_PAD,
                                  instr_word[cit_pkg::COND_HI:cit_pkg::COND_LO]} // RL15
                   : {cit_pkg::OP_PAD, dec_sub};

    // single operand cycles; the byte flag never enters a cost
    assign sgl_cycles = (dec_sub == cit_pkg::SUB_RETURN_FROM_INTERRUPT) ? cit_pkg::CYC_RETURN_FROM_INTERRUPT // RL2
                      : (dec_sub == cit_pkg::SUB_PUSH) ? cit_pkg::CYC_PUSH[src_mode] // RL5
                      : (dec_sub == cit_pkg::SUB_CALL) ? cit_pkg::CYC_CALL[src_mode] // RL6
                      : cit_pkg::CYC_SHIFT[src_mode]; // RL4 RL17

    // cost selection from format, modes and the single operand sub-range, never the double operation
    assign dec_cycles = illegal   ? cit_pkg::CYC_ILL
                      : is_jump   ? cit_pkg::CYC_JUMP // RL9
                      : is_double ? cit_pkg::CYC_DBL[src_mode][dst_cls] // RL1 RL10 RL11 RL12 RL13
                      : sgl_cycles; // RL1
    assign dec_words  = illegal   ? cit_pkg::WRD_ILL
                      : is_jump   ? cit_pkg::WRD_JUMP // RL9
                      : is_double ? cit_pkg::WRD_DBL[src_mode][dst_cls] // RL10 RL11 RL12 RL13
                      : (dec_sub == cit_pkg::SUB_RETURN_FROM_INTERRUPT) ? cit_pkg::WRD_RETURN_FROM_INTERRUPT // RL2
                      : cit_pkg::WRD_SGL[src_mode]; // RL7 RL17

    // sequencer: counts each slot down to its last cycle
    always_comb
    begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        done_d       = 1'b0;
        irq_ack_d    = 1'b0;
        reset_done_d = 1'b0;
        if (reset_hold)
        begin
            state_d = cit_pkg::ST_RESET;
            cnt_d   = cit_pkg::CYC_RESET; // RL3
        end
        else
        begin
            case (state_q)
                cit_pkg::ST_RESET:
                begin
                    if (cnt_q == cit_pkg::CNT_ONE)
                    begin
                        state_d      = cit_pkg::ST_IDLE;
                        reset_done_d = 1'b1; // RL3
                    end
                    else
                    begin
                        cnt_d = cnt_q - cit_pkg::CNT_ONE;
                    end
                end
                cit_pkg::ST_IDLE:
                begin
                    if (irq_take)
                    begin
                        state_d = cit_pkg::ST_IRQ;
                        cnt_d   = cit_pkg::CYC_IRQ - cit_pkg::CNT_ONE; // RL2
                    end
                    else if (accept && (dec_cycles == cit_pkg::CNT_ONE))
                    begin
                        done_d = 1'b1;
                    end
                    else if (accept)
                    begin
                        state_d = cit_pkg::ST_EXEC;
                        cnt_d   = dec_cycles - cit_pkg::CNT_ONE; // RL1
                    end
                end
                cit_pkg::ST_EXEC:
                begin
                    if (cnt_q == cit_pkg::CNT_ONE)
                    begin
                        state_d = cit_pkg::ST_IDLE;
                        done_d  = 1'b1;
                    end
                    else
                    begin
                        cnt_d = cnt_q - cit_pkg::CNT_ONE;
                    end
                end
                cit_pkg::ST_IRQ:
                begin
                    if (cnt_q == cit_pkg::CNT_ONE)
                    begin
                        state_d   = cit_pkg::ST_IDLE;
                        irq_ack_d = 1'b1; // RL2
                    end
                    else
                    begin
                        cnt_d = cnt_q - cit_pkg::CNT_ONE;
                    end
                end
                default:
                begin
                    state_d = cit_pkg::ST_RESET;
                    cnt_d   = cit_pkg::CYC_RESET;
                end
            endcase
        end
    end

    // sequencer state and slot-end pulses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q      <= cit_pkg::ST_RESET;
            cnt_q        <= cit_pkg::CYC_RESET;
            done_q       <= 1'b0;
            irq_ack_q    <= 1'b0;
            reset_done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            done_q       <= done_d;
            irq_ack_q    <= irq_ack_d;
            reset_done_q <= reset_done_d;
        end
    end

    // decode result captured when an instruction is taken
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fmt_q           <= cit_pkg::FMT_NONE;
            op_q            <= 4'h0;
            byte_q          <= 1'b0;
            mode_q          <= cit_pkg::MODE_REG;
            dst_q           <= cit_pkg::DST_REG;
            cycles_q        <= 3'h0;
            words_q         <= 2'h0;
            illegal_q       <= 1'b0;
            unpredictable_q <= 1'b0;
        end
        else if (clk_en && accept)
        begin
            fmt_q           <= dec_fmt;
            op_q            <= dec_op;
            byte_q          <= instr_word[cit_pkg::BW_BIT];
            mode_q          <= src_mode;
            dst_q           <= dst_cls;
            cycles_q        <= dec_cycles;
            words_q         <= dec_words;
            illegal_q       <= illegal;
            unpredictable_q <= is_single & shift_grp
                               & (src_mode == cit_pkg::MODE_IMM); // RL8
        end
    end

    // timing of slots, checked against fixed figures
    sequence s_quiet4;
        (!done_q && !instr_ready)[*4];
    endsequence

    sequence s_irq_hold5;
        (state_q == cit_pkg::ST_IRQ)[*5];
    endsequence

    property p_return_from_interrupt_five;
        @(posedge clk) disable iff (sys_rst || !clk_en || reset_hold)
        (accept && is_single && !illegal && dec_sub == cit_pkg::SUB_RETURN_FROM_INTERRUPT)
        |-> ##1 s_quiet4 ##1 (done_q && cycles_q == 3'h5 && words_q == 2'h1);
    endproperty

    property p_irq_six;
        @(posedge clk) disable iff (sys_rst || !clk_en || reset_hold)
        irq_take |-> ##1 s_irq_hold5 ##1 (irq_ack_q && instr_ready == !irq_req);
    endproperty

    a_return_from_interrupt_slot: assert property (p_return_from_interrupt_five) // RL2
        else $error("return from interrupt slot not five cycles");

    a_irq_entry: assert property (p_irq_six) // RL2
        else $error("interrupt entry not six cycles");

    a_reset_seq: assert property ( // RL3
        @(posedge clk) disable iff (sys_rst || !clk_en)
        ($fell(reset_hold) ##0 !reset_hold[*4])
        |-> ##1 (state_q == cit_pkg::ST_IDLE) && reset_done_q
            && $past(state_q, 4) == cit_pkg::ST_RESET)
        else $error("reset sequence not four cycles");

    a_jump_slot: assert property ( // RL9
        @(posedge clk) disable iff (sys_rst || !clk_en || reset_hold)
        (accept && is_jump)
        |=> !done_q ##1 (done_q && cycles_q == 3'h2 && words_q == 2'h1
                         && fmt_q == cit_pkg::FMT_JUMP))
        else $error("jump slot not two cycles of one word");

    a_shift_cost: assert property ( // RL4
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_single && !illegal && shift_grp && src_mode != cit_pkg::MODE_IMM)
        |=> cycles_q == ((mode_q == cit_pkg::MODE_REG) ? 3'h1
                       : (mode_q == cit_pkg::MODE_IDX) ? 3'h4 : 3'h3))
        else $error("shift group cycle count wrong");

    a_push_cost: assert property ( // RL5
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_single && dec_sub == cit_pkg::SUB_PUSH)
        |=> cycles_q == ((mode_q == cit_pkg::MODE_REG) ? 3'h3
                       : (mode_q == cit_pkg::MODE_IND
                          || mode_q == cit_pkg::MODE_IMM) ? 3'h4 : 3'h5))
        else $error("push cycle count wrong");

    a_call_cost: assert property ( // RL6
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_single && !illegal && dec_sub == cit_pkg::SUB_CALL)
        |=> cycles_q == ((mode_q == cit_pkg::MODE_REG
                          || mode_q == cit_pkg::MODE_IND) ? 3'h4 : 3'h5))
        else $error("call cycle count wrong");

    a_single_len: assert property ( // RL7
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_single && !illegal && dec_sub != cit_pkg::SUB_RETURN_FROM_INTERRUPT)
        |=> words_q == ((mode_q == cit_pkg::MODE_IMM
                         || mode_q == cit_pkg::MODE_IDX) ? 2'h2 : 2'h1))
        else $error("single operand length wrong");

    a_regsrc_cost: assert property ( // RL10
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_double && src_mode == cit_pkg::MODE_REG)
        |=> {cycles_q, words_q} == ((dst_q == cit_pkg::DST_REG) ? 5'h05
                                  : (dst_q == cit_pkg::DST_PC) ? 5'h09 : 5'h12))
        else $error("register source cost wrong");

    a_indsrc_cost: assert property ( // RL11
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_double && src_mode == cit_pkg::MODE_IND)
        |=> {cycles_q, words_q} == ((dst_q == cit_pkg::DST_MEM) ? 5'h16 : 5'h09))
        else $error("indirect source cost wrong");

    a_incsrc_cost: assert property ( // RL12
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_double && (src_mode == cit_pkg::MODE_AINC
                                 || src_mode == cit_pkg::MODE_IMM))
        |=> cycles_q == ((dst_q == cit_pkg::DST_REG) ? 3'h2
                       : (dst_q == cit_pkg::DST_PC) ? 3'h3 : 3'h5)
            && words_q == ((dst_q == cit_pkg::DST_MEM) ? 2'h2 : 2'h1)
                          + ((mode_q == cit_pkg::MODE_IMM) ? 2'h1 : 2'h0))
        else $error("autoincrement or immediate source cost wrong");

    a_idxsrc_cost: assert property ( // RL13
        @(posedge clk) disable iff (sys_rst || !clk_en)
        (accept && is_double && src_mode == cit_pkg::MODE_IDX)
        |=> {cycles_q, words_q} == ((dst_q == cit_pkg::DST_MEM) ? 5'h1b : 5'h0e))
        else $error("indexed source cost wrong");

    a_format_map: assert property ( // RL14 RL15 RL16
        @(posedge clk) disable iff (sys_rst || !clk_en)
        accept |=> fmt_q == $past(dec_fmt)
            && (fmt_q != cit_pkg::FMT_DOUBLE || op_q == $past(instr_word[15:12]))
            && (fmt_q != cit_pkg::FMT_JUMP || op_q == {1'b0, $past(instr_word[12:10])}))
        else $error("opcode range mapped to wrong format");

endmodule

// ==== cit_mem_model.sv ====
/*
 * program memory model: offers one instruction word at a time to the core.
 * assumes the bench raises go with a word just after a falling edge.
 */
module cit_mem_model
(
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] word,
    input  wire logic        instr_ready,
    output logic             instr_valid,
    output logic      [15:0] instr_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic taken;
    initial
    begin
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
    end
    // note the edge at which the core took the word
    always @(posedge clk)
        taken <= instr_valid & instr_ready;
    // hold the word until taken; a released bus shows the inverse, not a stale copy
    always @(negedge clk)
    begin
        if (go)
        begin
            instr_valid <= 1'b1;
            instr_word  <= word;
        end
        else if (taken)
        begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
    end
endmodule

// ==== cit_pkg.sv ====
/*
 * instruction timing package and the two-flop synchroniser used by the
 * timing core. assumes one clock (clk, 20 MHz) and an active-high
 * asynchronous reset; the synchroniser stalls with the core's clock enable.
 */
// Summary of operation
// RL1 - cycle count from format and modes only; the single operand cost here also depends on the sub-opcode (bits 9:7)
// RL2 - interrupt return 5 cycles, entry 6 cycles
// RL3 - watchdog or pin reset sequences 4 cycles
// RL4 - shift group costs 1, 3, 4 cycles
// RL5 - push costs 3, 4, 5 cycles
// RL6 - call costs 4 or 5 cycles
// RL7 - single operand is 1 or 2 words
// RL8 - program never uses shift group immediate
// RL9 - every jump is 1 word, 2 cycles
// RL10 - register source: 1/2/4 cycles, 1/1/2 words
// RL11 - indirect source: 2/2/5 cycles, 1/1/2 words
// RL12 - autoincrement and immediate source cost table
// RL13 - indexed source: 3/3/6 cycles, 2/2/3 words
// RL14 - 1xxx decodes the single operand group
// RL15 - 20xx to 3Cxx decode eight jumps
// RL16 - 4xxx to Fxxx decode twelve double operations
// RL17 - byte forms cost as word forms
package cit_pkg;

    // instruction field positions
    localparam int PFX1_HI = 15;
    localparam int PFX1_LO = 10;
    localparam int PFXJ_LO = 13;
    localparam int TOP_LO  = 12;
    localparam int SREG_HI = 11;
    localparam int SREG_LO = 8;
    localparam int SUB_HI  = 9;
    localparam int SUB_LO  = 7;
    localparam int COND_HI = 12;
    localparam int COND_LO = 10;
    localparam int AD_BIT  = 7;
    localparam int BW_BIT  = 6;
    localparam int AS_HI   = 5;
    localparam int AS_LO   = 4;
    localparam int DREG_HI = 3;
    localparam int DREG_LO = 0;

    // opcode prefixes
    localparam logic [5:0] SINGLE_PFX = 6'h04;
    localparam logic [2:0] JUMP_PFX   = 3'h1;
    localparam logic [3:0] DOUBLE_MIN = 4'h4;
    localparam logic [3:0] REG_PC     = 4'h0;
    localparam logic       OP_PAD     = 1'h0;

    // single operand sub-opcodes (bits 9:7)
    localparam logic [2:0] SUB_ROT  = 3'h0;
    localparam logic [2:0] SUB_SWAP = 3'h1;
    localparam logic [2:0] SUB_ASR  = 3'h2;
    localparam logic [2:0] SUB_SEXT = 3'h3;
    localparam logic [2:0] SUB_PUSH = 3'h4;
    localparam logic [2:0] SUB_CALL = 3'h5;
    localparam logic [2:0] SUB_RETURN_FROM_INTERRUPT = 3'h6;
    localparam logic [2:0] SUB_NONE = 3'h7;

    // source addressing field values
    localparam logic [1:0] AS_REG = 2'h0;
    localparam logic [1:0] AS_IDX = 2'h1;
    localparam logic [1:0] AS_IND = 2'h2;

    typedef enum logic [2:0]
    {
        MODE_REG  = 3'h0,
        MODE_IND  = 3'h1,
        MODE_AINC = 3'h2,
        MODE_IMM  = 3'h3,
        MODE_IDX  = 3'h4
    } cit_mode_e;

    typedef enum logic [1:0]
    {
        DST_REG = 2'h0,
        DST_PC  = 2'h1,
        DST_MEM = 2'h2
    } cit_dst_e;

    typedef enum logic [2:0]
    {
        FMT_NONE    = 3'h0,
        FMT_SINGLE  = 3'h1,
        FMT_JUMP    = 3'h2,
        FMT_DOUBLE  = 3'h3,
        FMT_ILLEGAL = 3'h4
    } cit_fmt_e;

    typedef enum logic [1:0]
    {
        ST_RESET = 2'h0,
        ST_IDLE  = 2'h1,
        ST_EXEC  = 2'h3,
        ST_IRQ   = 2'h2
    } cit_state_e;

    // fixed costs in clk cycles and code words
    localparam logic [2:0] CYC_RETURN_FROM_INTERRUPT  = 3'h5;
    localparam logic [1:0] WRD_RETURN_FROM_INTERRUPT  = 2'h1;
    localparam logic [2:0] CYC_IRQ   = 3'h6;
    localparam logic [2:0] CYC_RESET = 3'h4;
    localparam logic [2:0] CYC_JUMP  = 3'h2;
    localparam logic [1:0] WRD_JUMP  = 2'h1;
    localparam logic [2:0] CYC_ILL   = 3'h1;
    localparam logic [1:0] WRD_ILL   = 2'h1;
    localparam logic [2:0] CNT_ONE   = 3'h1;

    // single operand costs indexed by source mode: reg, ind, ainc, imm, idx
    // the shift group immediate entry is a don't-care filler
    localparam logic [2:0] CYC_SHIFT [5] = '{3'h1, 3'h3, 3'h3, 3'h4, 3'h4};
    localparam logic [2:0] CYC_PUSH  [5] = '{3'h3, 3'h4, 3'h5, 3'h4, 3'h5};
    localparam logic [2:0] CYC_CALL  [5] = '{3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
    localparam logic [1:0] WRD_SGL   [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2};

    // double operand costs [source mode][reg, pc, memory destination]
    localparam logic [2:0] CYC_DBL [5][3] = '{
        '{3'h1, 3'h2, 3'h4},
        '{3'h2, 3'h2, 3'h5},
        '{3'h2, 3'h3, 3'h5},
        '{3'h2, 3'h3, 3'h5},
        '{3'h3, 3'h3, 3'h6}};
    localparam logic [1:0] WRD_DBL [5][3] = '{
        '{2'h1, 2'h1, 2'h2},
        '{2'h1, 2'h1, 2'h2},
        '{2'h1, 2'h1, 2'h2},
        '{2'h2, 2'h2, 2'h3},
        '{2'h2, 2'h2, 2'h3}};

endpackage

// two-flop synchroniser for a level from outside the clock domain
module cit_sync
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // first flop feeds only the second
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ==== tb_cit_core.sv ====
/*
 * self-checking bench for the timing core: random and swept words,
 * interrupt entry and both reset sources. assumes clk_en held high.
 */
module tb_cit_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk, sys_rst, irq_req, wdt_rst, pin, go, instr_valid, instr_ready;
    logic [15:0]       word, instr_word, rw;
    logic [2:0]        cycles_q;
    logic [1:0]        words_q;
    logic [3:0]        op_q;
    logic              done_q, irq_ack_q, reset_done_q, byte_q, illegal_q, unpred_q;
    cit_pkg::cit_fmt_e fmt_q, ef;
    cit_pkg::cit_mode_e mode_q;
    cit_pkg::cit_dst_e dst_q;
    int                num_errors, n_tests, seed, n, e, m, d;

    cit_mem_model u_mem (.clk(clk), .go(go), .word(word), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_word(instr_word));
    cit_core DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .instr_word(instr_word),
        .instr_valid(instr_valid), .irq_req(irq_req), .watchdog_timer_rst(wdt_rst),
        .rst_nmi_pin(pin), .instr_ready(instr_ready), .fmt_q(fmt_q), .op_q(op_q),
        .byte_q(byte_q), .mode_q(mode_q), .dst_q(dst_q), .cycles_q(cycles_q),
        .words_q(words_q), .illegal_q(illegal_q), .unpredictable_q(unpred_q),
        .done_q(done_q), .irq_ack_q(irq_ack_q),
        .reset_done_q(reset_done_q), .state_q());

    // reference cost: cycles * 4 + words, format left in ef
    function automatic int cost(logic [15:0] w);
        int sh[5] = '{1, 3, 3, 4, 4};
        int pu[5] = '{3, 4, 5, 4, 5};
        int ca[5] = '{4, 4, 5, 5, 5};
        int dc[5][3] = '{'{1, 2, 4}, '{2, 2, 5}, '{2, 3, 5}, '{2, 3, 5}, '{3, 3, 6}};
        int s, r;
        s = w[15:14] == 2'h0 ? w[3:0] : w[11:8];
        m = w[5:4] == 2'h0 ? 0 : w[5:4] == 2'h1 ? 4 : w[5:4] == 2'h2 ? 1 : s == 0 ? 3 : 2;
        d = w[7] ? 2 : w[3:0] == 4'h0 ? 1 : 0;
        r = w[9:7];
        ef = cit_pkg::FMT_DOUBLE;
        if (w[15:14] != 2'h0)
            return dc[m][d] * 4 + 1 + (m >= 3) + (d == 2);
        ef = cit_pkg::FMT_JUMP;
        if (w[15:13] == 3'h1)
            return 9;
        ef = cit_pkg::FMT_ILLEGAL;
        if (w[15:10] != 6'h04 || r == 7 || (w[6] && (r % 2 == 1 || r == 6)))
            return 5;
        ef = cit_pkg::FMT_SINGLE;
        if (r == 6)
            return 21;
        if (r == 4)
            return pu[m] * 4 + 1 + (m >= 3);
        if (r == 5)
            return ca[m] * 4 + 1 + (m >= 3);
        return sh[m] * 4 + 1 + (m >= 3);
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(string nm, int exp, logic [7:0] got);
        n_tests++;
        if (got !== exp[7:0])
        begin
            num_errors++;
            $display("FAIL %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // count falling edges until a pulse shows, bounded
    task automatic wait_ev(string nm, int sel, int exp);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((sel ? reset_done_q : irq_ack_q) !== 1'b1 && n < 40);
        chk(nm, exp, 8'(n));
        if (n >= 40)
            close_out();
    endtask

    // offer one word, then check decode and the cycle of done
    task automatic send(logic [15:0] w);
        e = cost(w);
        word <= w;
        go <= 1'b1;
        @(negedge clk) go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(instr_valid === 1'b1 && instr_ready === 1'b1) && n < 40);
        if (n >= 40)
        begin
            chk("accept", 1, 8'h00);
            close_out();
        end
        @(negedge clk);
        chk("fmt", ef, 8'(fmt_q));
        chk("cycles", (e >> 2) & 7, 8'(cycles_q));
        chk("words", e & 3, 8'(words_q));
        chk("mode", m, 8'(mode_q));
        chk("dst", d, 8'(dst_q));
        chk("byte", w[6], 8'(byte_q));
        chk("illegal", ef == cit_pkg::FMT_ILLEGAL, 8'(illegal_q));
        chk("unpred", 0, 8'(unpred_q));
        if (w[15:13] != 3'h0)
            chk("op", w[15:14] != 2'h0 ? w[15:12] : w[12:10], 8'(op_q));
        n = 1;
        while (done_q !== 1'b1 && n < 9)
        begin
            @(negedge clk);
            n++;
        end
        chk("done", (e >> 2) & 7, 8'(n));
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        seed = 87885;
        {sys_rst, irq_req, wdt_rst, pin, go} = 5'h10;
        word = 16'h0000;
        num_errors = 0;
        n_tests = 0;
        repeat (10) @(negedge clk);
        sys_rst <= 1'b0;
        wait_ev("reset", 1, 4);
        // first sixteen sweep the top nibble, the rest are random
        for (int i = 0; i < 300; i++)
        begin
            rw = 16'($random(seed));
            if (i < 16)
                rw[15:12] = i[3:0];
            if (rw[15:10] == 6'h04 && !rw[9] && rw[5:4] == 2'h3 && rw[3:0] == 4'h0)
                rw[4] = 1'b0;
            send(rw);
        end
        $display("test instruction timing done");
        irq_req <= 1'b1;
        wait_ev("irq", 0, 6);
        irq_req <= 1'b0;
        $display("test interrupt entry done");
        wdt_rst <= 1'b1;
        @(negedge clk) wdt_rst <= 1'b0;
        wait_ev("wdt", 1, 4);
        pin <= 1'b1;
        @(negedge clk) pin <= 1'b0;
        wait_ev("pin", 1, 6);
        $display("test reset sources done");
        close_out();
    end
endmodule
